// ---- common/mbsr_pkg.sv ----
// Package for the Modbus ASCII status-word reader: constants and types
package mbsr_pkg;
	localparam logic [7:0] CHR_COLON = 8'h3A;
	localparam logic [7:0] CHR_CR = 8'h0D;
	localparam logic [7:0] CHR_LF = 8'h0A;
	localparam logic [7:0] FUNC_READ = 8'h03;
	localparam logic [15:0] ADDR_STATUS_ONE = 16'h9005;
	localparam logic [15:0] ADDR_STATUS_TWO = 16'h9006;
	localparam logic [15:0] REG_COUNT_ONE = 16'h0001;
	localparam logic [7:0] BYTE_COUNT_ONE = 8'h02;
	localparam logic [7:0] SLAVE_ADDR_MIN = 8'h01;
	localparam logic [7:0] SLAVE_ADDR_MAX = 8'h10;
	localparam logic [3:0] QUERY_BYTES = 4'h6;
	localparam logic [3:0] REPLY_BYTES = 4'h6;
	localparam logic [15:0] STATUS_RESET = 16'h0000;

	// One character on the serial byte stream
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} mbsr_char_t;

	typedef enum logic [2:0] {
		MBSR_IDLE,
		MBSR_HI,
		MBSR_LO,
		MBSR_CR,
		MBSR_LF
	} mbsr_rx_state_t;
endpackage

// ---- verilog/mbsr_hex.sv ----
// Single-character hex digit to nibble decoder
`timescale 1ns/1ps
`default_nettype none
module mbsr_hex (
	input wire logic [7:0] chr,
	output logic [3:0] nib,
	output logic ok
);
	// Digits 0-9 and upper-case A-F only
	wire is_num = (chr >= 8'h30) && (chr <= 8'h39);
	wire is_alpha = (chr >= 8'h41) && (chr <= 8'h46);
	assign ok = is_num || is_alpha;
	assign nib = is_num ? chr[3:0] : 4'(chr[3:0] + 4'h9);
endmodule
`default_nettype wire

// ---- verilog/mbsr_reader.sv ----
// Modbus ASCII responder for the two device status words
`timescale 1ns/1ps
`default_nettype none
module mbsr_reader (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] axis_num,
	input wire logic [15:0] device_status_one,
	input wire logic [15:0] device_status_two,
	input wire mbsr_pkg::mbsr_char_t rx_char,
	output mbsr_pkg::mbsr_char_t tx_char,
	input wire logic tx_ready,
	output logic busy,
	output logic frame_error
);
	// Hex nibble to ASCII upper-case digit
	function automatic logic [7:0] hex_chr(input logic [3:0] n);
		hex_chr = (n < 4'hA) ? {4'h3, n} : 8'(8'h37 + {4'h0, n});
	endfunction

	mbsr_pkg::mbsr_rx_state_t st_q, st_d;
	logic [7:0] buf_q [0:5];
	logic [3:0] idx_q;
	logic [3:0] hi_q;
	logic [7:0] sum_q;
	logic [7:0] rep_q [0:5];
	logic [3:0] tx_idx_q;
	logic [1:0] tx_ph_q;
	logic tx_act_q;
	mbsr_pkg::mbsr_char_t tx_q;
	logic err_q;

	wire [3:0] nib;
	wire nib_ok;
	mbsr_hex u_hex (
		.chr(rx_char.data),
		.nib(nib),
		.ok(nib_ok)
	);

	// Own slave address is axis number plus one
	wire [7:0] own_addr = 8'({4'h0, axis_num} + 8'h01);
	wire [7:0] full_byte = {hi_q, nib};
	wire in_char = rx_char.valid && !tx_act_q;
	wire is_colon = in_char && rx_char.data == mbsr_pkg::CHR_COLON;
	// Frame check after the LF: LRC is summed in, so total is zero
	wire [15:0] q_addr = {buf_q[2], buf_q[3]};
	wire [15:0] q_cnt = {buf_q[4], buf_q[5]};
	wire lrc_good = (sum_q == 8'h00) && (idx_q == 4'h7);
	wire hdr_good = buf_q[0] == own_addr && buf_q[1] == mbsr_pkg::FUNC_READ
		&& q_cnt == mbsr_pkg::REG_COUNT_ONE;
	wire is_one = q_addr == mbsr_pkg::ADDR_STATUS_ONE;
	wire is_two = q_addr == mbsr_pkg::ADDR_STATUS_TWO;
	wire frame_end = in_char && st_q == mbsr_pkg::MBSR_LF && rx_char.data == mbsr_pkg::CHR_LF;
	wire accept = frame_end && lrc_good && hdr_good && (is_one || is_two);
	// Word two for 9006h, word one for 9005h
	wire [15:0] sel_word = is_two ? device_status_two : device_status_one;
	// Reply LRC is the two's complement of the byte sum
	wire [7:0] rep_sum = 8'(own_addr + mbsr_pkg::FUNC_READ + mbsr_pkg::BYTE_COUNT_ONE
		+ sel_word[15:8] + sel_word[7:0]);
	wire [7:0] rep_lrc = 8'(8'h00 - rep_sum);

	// Receive state sequencing
	always_comb
	begin
		st_d = st_q;
		if (is_colon)
			st_d = mbsr_pkg::MBSR_HI;
		else if (in_char)
		begin
			case (st_q)
				mbsr_pkg::MBSR_HI:
					if (rx_char.data == mbsr_pkg::CHR_CR)
						st_d = mbsr_pkg::MBSR_LF;
					else if (nib_ok && idx_q < 4'h7)
						st_d = mbsr_pkg::MBSR_LO;
					else
						st_d = mbsr_pkg::MBSR_IDLE;
				mbsr_pkg::MBSR_LO:
					st_d = nib_ok ? mbsr_pkg::MBSR_HI : mbsr_pkg::MBSR_IDLE;
				mbsr_pkg::MBSR_LF:
					st_d = mbsr_pkg::MBSR_IDLE;
				default:
					st_d = mbsr_pkg::MBSR_IDLE;
			endcase
		end
	end

	// Receive registers: byte assembly and running sum
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q <= mbsr_pkg::MBSR_IDLE;
			idx_q <= 4'h0;
			hi_q <= 4'h0;
			sum_q <= 8'h00;
			for (int i = 0; i < 6; i++)
				buf_q[i] <= 8'h00;
		end
		else
		begin
			st_q <= st_d;
			if (is_colon)
			begin
				idx_q <= 4'h0;
				sum_q <= 8'h00;
			end
			else if (in_char && st_q == mbsr_pkg::MBSR_HI)
				hi_q <= nib;
			else if (in_char && st_q == mbsr_pkg::MBSR_LO && nib_ok)
			begin
				sum_q <= 8'(sum_q + full_byte);
				if (idx_q < 4'h6)
					buf_q[idx_q[2:0]] <= full_byte;
				idx_q <= 4'(idx_q + 4'h1);
			end
		end
	end

	// Error flag pulses on a complete frame that fails the LRC or length check
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			err_q <= 1'b0;
		else
			err_q <= frame_end && !lrc_good;
	end

	// Reply load and character sequencing
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_act_q <= 1'b0;
			tx_idx_q <= 4'h0;
			tx_ph_q <= 2'h0;
			tx_q <= '0;
			for (int i = 0; i < 6; i++)
				rep_q[i] <= 8'h00;
		end
		else if (accept)
		begin
			rep_q[0] <= own_addr;
			rep_q[1] <= mbsr_pkg::FUNC_READ;
			rep_q[2] <= mbsr_pkg::BYTE_COUNT_ONE;
			rep_q[3] <= sel_word[15:8];
			rep_q[4] <= sel_word[7:0];
			rep_q[5] <= rep_lrc;
			tx_act_q <= 1'b1;
			tx_idx_q <= 4'h0;
			tx_ph_q <= 2'h0;
			tx_q <= '{valid: 1'b1, data: mbsr_pkg::CHR_COLON};
		end
		else if (tx_act_q && tx_q.valid && tx_ready)
		begin
			// Phase 0: high digit next, 1: low digit, then CR LF
			if (tx_idx_q == mbsr_pkg::REPLY_BYTES)
			begin
				if (tx_ph_q == 2'h0)
				begin
					tx_q.data <= mbsr_pkg::CHR_CR;
					tx_ph_q <= 2'h1;
				end
				else if (tx_ph_q == 2'h1)
				begin
					tx_q.data <= mbsr_pkg::CHR_LF;
					tx_ph_q <= 2'h2;
				end
				else
				begin
					tx_q <= '0;
					tx_act_q <= 1'b0;
				end
			end
			else if (tx_ph_q == 2'h0)
			begin
				tx_q.data <= hex_chr(rep_q[tx_idx_q[2:0]][7:4]);
				tx_ph_q <= 2'h1;
			end
			else
			begin
				tx_q.data <= hex_chr(rep_q[tx_idx_q[2:0]][3:0]);
				tx_ph_q <= 2'h0;
				tx_idx_q <= 4'(tx_idx_q + 4'h1);
			end
		end
	end

	assign tx_char = tx_q;
	assign busy = tx_act_q;
	assign frame_error = err_q;

	a_reply_count: assert property (@(posedge clk) disable iff (!rst_n)
		accept |=> rep_q[2] == 8'h02)
		else $error("byte count not 02");
	a_word_two: assert property (@(posedge clk) disable iff (!rst_n)
		accept && is_two |=> {rep_q[3], rep_q[4]} == $past(device_status_two))
		else $error("wrong word for 9006h");
	a_lrc_zero: assert property (@(posedge clk) disable iff (!rst_n)
		accept |=> 8'(rep_q[0] + rep_q[1] + rep_q[2] + rep_q[3] + rep_q[4] + rep_q[5]) == 8'h00)
		else $error("reply LRC wrong");
	a_bad_ignored: assert property (@(posedge clk) disable iff (!rst_n)
		frame_end && !lrc_good |=> frame_error && !busy)
		else $error("bad frame answered");
	a_addr_match: assert property (@(posedge clk) disable iff (!rst_n)
		accept |=> rep_q[0] == 8'(axis_num + 8'h01))
		else $error("reply address mismatch");
	a_start_colon: assert property (@(posedge clk) disable iff (!rst_n)
		accept |=> tx_char.valid && tx_char.data == 8'h3A)
		else $error("reply does not open with colon");
endmodule
`default_nettype wire

// ---- testbench/mbsr_master.sv ----
// Modbus ASCII master model that queries the status-word reader
`timescale 1ns/1ps
`default_nettype none
module mbsr_master (
	input wire logic clk,
	output mbsr_pkg::mbsr_char_t rx_char,
	input wire mbsr_pkg::mbsr_char_t tx_char,
	output logic tx_ready
);
	logic [7:0] got[$];
	logic slow;
	initial
	begin
		rx_char = '0;
		tx_ready = 1'b1;
		slow = 1'b0;
	end
	// Stalls every other cycle when slow
	always @(negedge clk)
		tx_ready <= slow ? ~tx_ready : 1'b1;
	// Takes a reply char on valid and ready
	always @(posedge clk)
		if (tx_char.valid && tx_ready)
			got.push_back(tx_char.data);
	// Upper-case ASCII hex digit
	function automatic logic [7:0] hx(input logic [3:0] n);
		return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
	endfunction
	// Sends a framed query back to back; skew spoils the LRC
	task automatic query(input logic [47:0] b, input logic [7:0] skew, output logic [7:0] lrc);
		logic [55:0] f;
		lrc = 8'(-(b[47:40] + b[39:32] + b[31:24] + b[23:16] + b[15:8] + b[7:0])) + skew;
		f = {b, lrc};
		@(negedge clk) rx_char = {1'b1, 8'h3A};
		for (int i = 13; i >= 0; i--)
			@(negedge clk) rx_char = {1'b1, hx(f[i * 4 +: 4])};
		@(negedge clk) rx_char = {1'b1, 8'h0D};
		@(negedge clk) rx_char = {1'b1, 8'h0A};
		@(negedge clk) rx_char = '0;
	endtask
endmodule
`default_nettype wire

// ---- testbench/mbsr_reader_bench.sv ----
// Self-checking bench for the Modbus ASCII status-word reader
`timescale 1ns/1ps
`default_nettype none
module mbsr_reader_bench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] axis_num = 4'h0;
	logic [15:0] word_one = 16'h3088;
	logic [15:0] word_two = 16'h8000;
	mbsr_pkg::mbsr_char_t rx_char, tx_char;
	logic tx_ready, busy, frame_error;
	logic [7:0] lrc;
	int n_mismatch = 0;
	int comparisons = 0;
	int n_ferr = 0;
	always #2.5 clk = ~clk;
	mbsr_reader u_mbsr_reader (.clk(clk), .rst_n(rst_n), .axis_num(axis_num),
		.device_status_one(word_one), .device_status_two(word_two), .rx_char(rx_char),
		.tx_char(tx_char), .tx_ready(tx_ready), .busy(busy), .frame_error(frame_error));
	mbsr_master u_mbsr_master (.clk(clk), .rx_char(rx_char), .tx_char(tx_char),
		.tx_ready(tx_ready));
	// Counts error pulses
	always @(posedge clk)
		if (frame_error === 1'b1)
			n_ferr++;
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Query, bounded wait, then the reply digit by digit
	task automatic xfer(input logic [7:0] a, input logic [15:0] st, input logic [15:0] w,
		input logic [7:0] skew, input bit want);
		logic [47:0] r;
		logic [7:0] e;
		r = {a, 8'h03, 8'h02, w, 8'(-(a + 8'h05 + w[15:8] + w[7:0]))};
		u_mbsr_master.got.delete();
		n_ferr = 0;
		u_mbsr_master.query({a, 8'h03, st, 16'h0001}, skew, lrc);
		for (int i = 0; i < 200 && !(u_mbsr_master.got.size() == 15 && busy === 1'b0); i++)
			@(negedge clk);
		chk("reply_len", 16'(u_mbsr_master.got.size()), want ? 16'h000F : 16'h0000);
		chk("busy_end", 16'(busy), 16'h0000);
		if (want && u_mbsr_master.got.size() != 15)
			stop_test();
		// Expected reply: colon, twelve digits, CR, LF
		for (int i = 0; want && i < 15; i++)
		begin
			e = (i == 0) ? 8'h3A : (i == 13) ? 8'h0D : 8'h0A;
			if (i > 0 && i < 13)
				e = u_mbsr_master.hx(r[(12 - i) * 4 +: 4]);
			chk("reply_char", {8'h00, u_mbsr_master.got[i]}, {8'h00, e});
		end
	endtask
	// Word one sample exchange at axis 0
	task automatic t_word_one();
		xfer(8'h01, 16'h9005, 16'h3088, 8'h00, 1'b1);
		chk("query_lrc", {8'h00, lrc}, 16'h0066);
		chk("reply_lrc", {u_mbsr_master.got[11], u_mbsr_master.got[12]}, 16'h3432);
	endtask
	// Word two right after, with a stalling consumer
	task automatic t_word_two();
		u_mbsr_master.slow = 1'b1;
		xfer(8'h01, 16'h9006, 16'h8000, 8'h00, 1'b1);
		u_mbsr_master.slow = 1'b0;
		chk("query_lrc", {8'h00, lrc}, 16'h0065);
		chk("data_hi", {u_mbsr_master.got[7], u_mbsr_master.got[8]}, 16'h3830);
		chk("reply_lrc", {u_mbsr_master.got[11], u_mbsr_master.got[12]}, 16'h3741);
		word_two = 16'h5AC3;
		xfer(8'h01, 16'h9006, 16'h5AC3, 8'h00, 1'b1);
		chk("data_new", {u_mbsr_master.got[7], u_mbsr_master.got[8]}, 16'h3541);
		word_two = 16'h8000;
	endtask
	// Top axis answers at 10h, ignores a foreign address
	task automatic t_axis();
		axis_num = 4'hF;
		xfer(8'h10, 16'h9005, 16'h3088, 8'h00, 1'b1);
		xfer(8'h01, 16'h9005, 16'h3088, 8'h00, 1'b0);
		chk("foreign_err", 16'(n_ferr), 16'h0000);
		axis_num = 4'h0;
	endtask
	// Bad checksum dropped with one error pulse
	task automatic t_bad_lrc();
		xfer(8'h01, 16'h9006, 16'h8000, 8'h01, 1'b0);
		chk("lrc_err", 16'(n_ferr), 16'h0001);
	endtask
	initial
	begin
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		t_word_one();
		t_word_two();
		t_axis();
		t_bad_lrc();
		stop_test();
	end
endmodule
`default_nettype wire
